// *** include/capture_cfg.svh ***
`ifndef CAPTURE_CFG_SVH
`define CAPTURE_CFG_SVH

// ****************************************
// Capacity limits of one capture file
// ****************************************
`define CAP_MBYTES 6
`define CAP_BYTE_LIMIT (`CAP_MBYTES * 1024 * 1024)
`define CAP_BYTE_W 23
`define CAP_PKT_LIMIT 3904
`define CAP_PKT_W 12

// ****************************************
// File naming
// ****************************************
`define CAP_GEN_MAX 999
`define CAP_GEN_W 10
`define CAP_GEN_RESET 10'h000

// ****************************************
// Data path buffer
// ****************************************
`define CAP_FIFO_WIDTH 9
`define CAP_FIFO_DEPTH 4
`define CAP_LAST_BIT 8

`endif

// *** include/capture_pkg.sv ***
`include "capture_cfg.svh"

package capture_pkg;
	typedef logic [`CAP_BYTE_W-1:0] byte_cnt_t;
	typedef logic [`CAP_PKT_W-1:0] pkt_cnt_t;
	typedef logic [`CAP_GEN_W-1:0] gen_t;
	typedef logic [13:0] year_t;
	typedef logic [3:0] month_t;
	typedef logic [4:0] day_t;
	typedef logic [4:0] hour_t;
	typedef logic [5:0] minute_t;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CAPTURE,
		ST_DRAIN
	} state_t;
endpackage

// *** src/capture_fifo.sv ***
`timescale 1ns/10ps

module capture_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input wire logic clk, // System clock
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic in_valid, // Write side data valid
	input wire logic [WIDTH-1:0] in_data, // Write side data
	output logic in_ready, // Room for one more word, registered
	output logic out_valid, // Read side data valid, registered
	output logic [WIDTH-1:0] out_data, // Read side data, registered
	input wire logic out_ready // Read side takes the word
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	wire push = in_valid && in_ready;
	wire pop = (cnt_q != '0) && (!out_valid || out_ready);

	function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
		ptr_next = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign cnt_d = cnt_q + CW'(push) - CW'(pop);

	// ****************************************
	// Storage; read data leave through a register
	// ****************************************
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
			out_data <= '0;
		end else begin
			cnt_q <= cnt_d;
			// Registered ready from the next count drops in the cycle the buffer becomes full
			in_ready <= (cnt_d < CW'(DEPTH));
			if (push) begin
				wr_ptr_q <= ptr_next(wr_ptr_q);
			end
			if (pop) begin
				rd_ptr_q <= ptr_next(rd_ptr_q);
				out_data <= mem_q[rd_ptr_q];
				out_valid <= 1'b1;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
		end
	end
endmodule // capture_fifo

// *** src/packet_capture_ctrl.sv ***
`timescale 1ns/10ps
`include "capture_cfg.svh"


module packet_capture_ctrl (
	input wire logic clk, // 200 MHz system clock
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic cycle_tick, // Controller cycle enable pulse
	input wire logic req_enable_cfg, // Request flag honoured when high
	input wire logic power_on_cfg, // Capture after power-up when high
	input wire logic capture_request_flag, // Host request, asynchronous
	output logic capture_active_flag, // Capture in progress
	output logic capacity_stop, // Last capture ended by a limit
	input wire logic frame_valid, // Fieldbus byte valid
	input wire logic [7:0] frame_data, // Fieldbus byte
	input wire logic frame_last, // Byte ends its packet
	output logic frame_ready, // Byte taken when valid
	input wire capture_pkg::year_t rtc_year, // Clock year
	input wire capture_pkg::month_t rtc_month, // Clock month
	input wire capture_pkg::day_t rtc_day, // Clock day
	input wire capture_pkg::hour_t rtc_hour, // Clock hour
	input wire capture_pkg::minute_t rtc_minute, // Clock minute
	output capture_pkg::year_t file_year, // Name: year
	output capture_pkg::month_t file_month, // Name: month
	output capture_pkg::day_t file_day, // Name: day
	output capture_pkg::hour_t file_hour, // Name: hour
	output capture_pkg::minute_t file_minute, // Name: minute
	output capture_pkg::gen_t file_gen, // Name: generation
	output logic card_open, // Pulse: open new file
	output logic card_close, // Pulse: close file
	output logic card_wr_valid, // Card write byte valid
	output logic [7:0] card_wr_data, // Card write byte
	output logic card_wr_last, // Card byte ends packet
	input wire logic card_wr_ready, // Card takes the byte
	input wire logic card_busy, // Card access in progress, async
	output logic card_activity_indicator // Card activity lamp
);
	import capture_pkg::*;

	// ****************************************
	// Synchronisers and request sampling
	// ****************************************
	logic req_s1_q;
	logic req_s2_q;
	logic req_smp_q;
	logic busy_s1_q;
	logic busy_s2_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			busy_s1_q <= 1'b0;
			busy_s2_q <= 1'b0;
		end else begin
			req_s1_q <= capture_request_flag;
			req_s2_q <= req_s1_q;
			busy_s1_q <= card_busy;
			busy_s2_q <= busy_s1_q;
		end
	end

	// Sampling only on the tick keeps a held request from re-arming
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			req_smp_q <= 1'b0;
		end else if (cycle_tick) begin
			req_smp_q <= req_s2_q;
		end
	end

	wire req_rise = cycle_tick && req_s2_q && !req_smp_q;
	wire req_fall = cycle_tick && !req_s2_q && req_smp_q;

	// ****************************************
	// Power-on capture arming
	// ****************************************
	logic por_seen_q;
	logic por_pend_q;

	// Setting caught by a clocked process after release, never by reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			por_seen_q <= 1'b0;
			por_pend_q <= 1'b0;
		end else begin
			por_seen_q <= 1'b1;
			if (!por_seen_q) begin
				por_pend_q <= power_on_cfg;
			end else begin
				por_pend_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Control decode
	// ****************************************
	state_t state_q;
	state_t state_d;
	byte_cnt_t byte_cnt_q;
	pkt_cnt_t pkt_cnt_q;
	gen_t gen_q;
	logic fifo_ready;
	logic fifo_out_valid;
	logic [`CAP_FIFO_WIDTH-1:0] fifo_out_data;
	logic push_q;

	function automatic gen_t gen_next(input gen_t g);
		gen_next = (g == `CAP_GEN_W'(`CAP_GEN_MAX)) ? `CAP_GEN_RESET :
			g + 1'b1;
	endfunction

	wire capturing = (state_q == ST_CAPTURE);
	wire req_start = req_rise && req_enable_cfg;
	wire start_go = (state_q == ST_IDLE) && (req_start || por_pend_q);
	wire accept = capturing && frame_valid && fifo_ready;
	wire byte_hit = accept &&
		(byte_cnt_q == `CAP_BYTE_W'(`CAP_BYTE_LIMIT - 1));
	wire pkt_hit = accept && frame_last &&
		(pkt_cnt_q == `CAP_PKT_W'(`CAP_PKT_LIMIT - 1));
	wire limit_stop = byte_hit || pkt_hit;
	wire stop_go = capturing && (req_fall || limit_stop);
	// A byte pushed into an empty buffer is invisible at its outputs
	// for one cycle, so the last push is remembered before closing
	wire drained = !push_q && !fifo_out_valid && !card_wr_valid;
	// Bytes cut at a capacity stop close their packet in the file
	wire push_last = frame_last || limit_stop;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (start_go) begin
					state_d = ST_CAPTURE;
				end
			end
			ST_CAPTURE: begin
				if (stop_go) begin
					state_d = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				if (drained) begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	// ****************************************
	// State, counters and flags
	// ****************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			capture_active_flag <= 1'b0;
			card_open <= 1'b0;
			card_close <= 1'b0;
			push_q <= 1'b0;
		end else begin
			state_q <= state_d;
			capture_active_flag <= (state_d == ST_CAPTURE);
			card_open <= start_go;
			card_close <= (state_q == ST_DRAIN) && drained;
			push_q <= accept;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			byte_cnt_q <= '0;
			pkt_cnt_q <= '0;
			capacity_stop <= 1'b0;
		end else if (start_go) begin
			byte_cnt_q <= '0;
			pkt_cnt_q <= '0;
			capacity_stop <= 1'b0;
		end else if (accept) begin
			byte_cnt_q <= byte_cnt_q + 1'b1;
			pkt_cnt_q <= pkt_cnt_q + `CAP_PKT_W'(frame_last);
			capacity_stop <= capacity_stop || limit_stop;
		end
	end

	// Generation rolls over so names stay three digits
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gen_q <= `CAP_GEN_RESET;
			file_gen <= `CAP_GEN_RESET;
			file_year <= '0;
			file_month <= '0;
			file_day <= '0;
			file_hour <= '0;
			file_minute <= '0;
		end else if (start_go) begin
			gen_q <= gen_next(gen_q);
			file_gen <= gen_q;
			file_year <= rtc_year;
			file_month <= rtc_month;
			file_day <= rtc_day;
			file_hour <= rtc_hour;
			file_minute <= rtc_minute;
		end
	end

	// ****************************************
	// Data path to the card
	// ****************************************
	capture_fifo #(
		.WIDTH(`CAP_FIFO_WIDTH),
		.DEPTH(`CAP_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.in_valid(capturing && frame_valid),
		.in_data({push_last, frame_data}),
		.in_ready(fifo_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(!card_wr_valid || card_wr_ready)
	);

	// Bytes outside a capture are taken and dropped while the buffer has room, so the link stalls only when it is full
	assign frame_ready = fifo_ready;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			card_wr_valid <= 1'b0;
			card_wr_data <= 8'h00;
			card_wr_last <= 1'b0;
		end else if (!card_wr_valid || card_wr_ready) begin
			card_wr_valid <= fifo_out_valid;
			card_wr_data <= fifo_out_data[7:0];
			card_wr_last <= fifo_out_data[`CAP_LAST_BIT];
		end
	end

	// Lamp covers both our writes and any access the card reports
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			card_activity_indicator <= 1'b0;
		end else begin
			card_activity_indicator <= busy_s2_q || card_wr_valid ||
				fifo_out_valid;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_stop_seen;
		capturing && req_fall;
	endsequence

	sequence s_flag_drops;
		!capture_active_flag ##1 !capture_active_flag;
	endsequence

	a_disabled_no_start: assert property (
		(state_q == ST_IDLE && !req_enable_cfg && !por_pend_q)
		|=> !capture_active_flag)
		else $error("capture started while request disabled");

	a_request_starts: assert property (
		(state_q == ST_IDLE && req_enable_cfg && cycle_tick &&
		req_s2_q && !req_smp_q) |=> capture_active_flag ##0 card_open)
		else $error("enabled request did not start capture");

	a_active_tracks: assert property (
		capture_active_flag == (state_q == ST_CAPTURE))
		else $error("active flag disagrees with capture state");

	a_request_off: assert property (
		s_stop_seen |=> s_flag_drops)
		else $error("capture continued after request off");

	a_byte_limit: assert property (
		capture_active_flag |->
		byte_cnt_q < `CAP_BYTE_W'(`CAP_BYTE_LIMIT))
		else $error("byte capacity exceeded while active");

	a_pkt_limit: assert property (
		(capturing && pkt_hit) |=> !capture_active_flag && capacity_stop)
		else $error("packet limit did not stop capture");

	a_power_on: assert property (
		(por_pend_q && state_q == ST_IDLE) |=> capture_active_flag)
		else $error("power-on capture did not start");

	a_gen_range: assert property (
		card_open |-> file_gen <= `CAP_GEN_W'(`CAP_GEN_MAX) &&
		$past(gen_q) == file_gen)
		else $error("generation out of range");

	a_lamp_on: assert property (
		card_wr_valid |=> card_activity_indicator)
		else $error("lamp dark during card write");

	a_held_no_restart: assert property (
		($fell(capture_active_flag) && capacity_stop && req_s2_q &&
		req_smp_q && !por_pend_q) |=> !card_open [*4])
		else $error("held request restarted capture");
endmodule // packet_capture_ctrl

// *** test/card_model.sv ***
`timescale 1ns/10ps

module card_model (
	input wire logic clk, // System clock
	input wire logic reset_n, // Reset, active low
	input wire logic stall, // Hold off writes
	input wire logic card_wr_valid, // Byte offered
	input wire logic [7:0] card_wr_data, // Byte value
	input wire logic card_wr_last, // Byte ends packet
	output logic card_wr_ready, // Byte taken
	output logic card_busy, // Card access in progress
	output logic [7:0] rx_data, // Last byte taken
	output int rx_count, // Bytes taken
	output int rx_pkts // Packets taken
);
	logic [2:0] busy_q;

	// ****************
	// Write side
	// ****************
	// Busy stays up a few cycles after each byte, as a real card programs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			card_wr_ready <= 1'b0;
			busy_q <= 3'h0;
			rx_data <= 8'h00;
			rx_count <= 0;
			rx_pkts <= 0;
		end else begin
			card_wr_ready <= !stall;
			busy_q <= {busy_q[1:0], 1'b0};
			if (card_wr_valid && card_wr_ready) begin
				rx_data <= card_wr_data;
				rx_count <= rx_count + 1;
				rx_pkts <= rx_pkts + int'(card_wr_last);
				busy_q <= 3'h7;
			end
		end
	end
	assign card_busy = |busy_q;
endmodule // card_model

// *** test/tb.sv ***
`timescale 1ns/10ps

module tb;
	import capture_pkg::*;
	logic clk = 0;
	logic reset_n = 0;
	logic cycle_tick = 0;
	logic req_enable_cfg = 0;
	logic power_on_cfg = 0;
	logic capture_request_flag = 0;
	logic frame_valid = 0;
	logic [7:0] frame_data = 8'h00;
	logic frame_last = 0;
	logic stall = 0;
	logic [2:0] tick_q = 3'h0;
	year_t rtc_year = 14'h07E9;
	month_t rtc_month = 4'hB;
	day_t rtc_day = 5'h1C;
	hour_t rtc_hour = 5'h17;
	minute_t rtc_minute = 6'h3B;
	year_t file_year;
	month_t file_month;
	day_t file_day;
	hour_t file_hour;
	minute_t file_minute;
	gen_t file_gen;
	gen_t exp_gen = 10'h000;
	logic capture_active_flag, capacity_stop, frame_ready, card_open;
	logic card_close, card_wr_valid, card_wr_last, card_wr_ready;
	logic card_busy, card_activity_indicator;
	logic [7:0] card_wr_data, rx_data;
	int rx_count, rx_pkts, n, base, i;
	int fail_count = 0;
	int tests_run = 0;
	int open_count = 0;
	int close_count = 0;
	int close_pkts = 0;

	packet_capture_ctrl uut (.clk, .reset_n, .cycle_tick, .req_enable_cfg,
		.power_on_cfg, .capture_request_flag, .capture_active_flag,
		.capacity_stop, .frame_valid, .frame_data, .frame_last, .frame_ready,
		.rtc_year, .rtc_month, .rtc_day, .rtc_hour, .rtc_minute, .file_year,
		.file_month, .file_day, .file_hour, .file_minute, .file_gen,
		.card_open, .card_close, .card_wr_valid, .card_wr_data,
		.card_wr_last, .card_wr_ready, .card_busy, .card_activity_indicator);
	card_model card (.clk, .reset_n, .stall, .card_wr_valid, .card_wr_data,
		.card_wr_last, .card_wr_ready, .card_busy, .rx_data, .rx_count,
		.rx_pkts);

	// ****************
	// Clock and controller cycle
	// ****************
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		tick_q <= tick_q + 3'h1;
		cycle_tick <= (tick_q == 3'h7);
	end

	// Pulse counters; close_pkts shows what the card held at close
	always @(posedge clk) begin
		if (card_open) open_count <= open_count + 1;
		if (card_close) begin
			close_count <= close_count + 1;
			close_pkts <= rx_pkts;
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic wait_active(input logic v);
		int j;
		for (j = 0; j < 60 && capture_active_flag !== v; j++) @(posedge clk);
		check(capture_active_flag, v);
	endtask

	// Leaves valid up so that back-to-back bytes need no extra cycle
	task automatic send(input logic [7:0] d, input logic l);
		int j;
		frame_valid <= 1'b1;
		frame_data <= d;
		frame_last <= l;
		@(posedge clk);
		for (j = 0; j < 60 && frame_ready !== 1'b1; j++) @(posedge clk);
		check(frame_ready, 1);
	endtask

	task automatic start();
		capture_request_flag <= 1'b1;
		wait_active(1'b1);
		check(card_open, 1);
		check(file_gen, exp_gen);
		exp_gen++;
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_basic();
		req_enable_cfg <= 1'b1;
		start();
		check(file_year, rtc_year);
		check(file_minute, rtc_minute);
		check(file_month, rtc_month);
		check(file_day, rtc_day);
		check(file_hour, rtc_hour);
		base = rx_count;
		for (i = 0; i < 6; i++) send(8'hA0 + i[7:0], i == 5);
		frame_valid <= 1'b0;
		cyc(20);
		check(rx_count - base, 6);
		check(rx_data, 8'hA5);
		check(capture_active_flag, 1);
		capture_request_flag <= 1'b0;
		wait_active(1'b0);
		check(capacity_stop, 0);
		cyc(5);
		check(close_count, 1);
		$display("%0t basic capture done", $time);
	endtask

	task automatic t_fifo();
		start();
		base = rx_count;
		stall <= 1'b1;
		cyc(3);
		n = 0;
		frame_valid <= 1'b1;
		frame_last <= 1'b0;
		frame_data <= 8'h10;
		repeat (16) begin
			@(posedge clk);
			if (frame_ready) begin
				n++;
				frame_data <= 8'h10 + n[7:0];
			end
		end
		check(frame_ready, 0);
		check(card_activity_indicator, 1);
		stall <= 1'b0;
		for (i = 0; i < 60 && frame_ready !== 1'b1; i++) @(posedge clk);
		check(frame_ready, 1);
		n++;
		frame_valid <= 1'b0;
		cyc(30);
		check(rx_count - base, n);
		check(rx_data, 8'h0F + n[7:0]);
		check(card_activity_indicator, 0);
		capture_request_flag <= 1'b0;
		wait_active(1'b0);
		$display("%0t buffer fill done", $time);
	endtask

	task automatic t_limit();
		start();
		base = rx_pkts;
		for (i = 0; i < 3903; i++) send(i[7:0], 1'b1);
		check(capture_active_flag, 1);
		send(8'h5A, 1'b1);
		frame_valid <= 1'b0;
		wait_active(1'b0);
		check(capacity_stop, 1);
		cyc(40);
		check(capture_active_flag, 0);
		check(rx_pkts - base, 3904);
		check(close_pkts - base, 3904);
		capture_request_flag <= 1'b0;
		cyc(30);
		$display("%0t packet limit done", $time);
	endtask

	task automatic t_power();
		power_on_cfg <= 1'b1;
		reset_n <= 1'b0;
		cyc(5);
		reset_n <= 1'b1;
		wait_active(1'b1);
		check(file_gen, 0);
		capture_request_flag <= 1'b1;
		cyc(30);
		check(capture_active_flag, 1);
		capture_request_flag <= 1'b0;
		wait_active(1'b0);
		$display("%0t power-on capture done", $time);
	endtask

	task automatic t_refused();
		check(capture_active_flag, 0);
		capture_request_flag <= 1'b1;
		cyc(30);
		check(capture_active_flag, 0);
		check(open_count, 0);
		capture_request_flag <= 1'b0;
		cyc(20);
		$display("%0t refused request done", $time);
	endtask

	initial begin
		cyc(5);
		check(frame_ready, 0);
		reset_n <= 1'b1;
		cyc(30);
		t_refused();
		t_basic();
		t_fifo();
		t_limit();
		t_power();
		stop_test();
	end

	initial begin
		cyc(30000);
		fail_count++;
		stop_test();
	end
endmodule // tb
